// [hw/lcrc_pkg.sv]
`default_nettype none
package lcrc_pkg;

	// --------------------------------------------------------------
	// Geometry
	// --------------------------------------------------------------
	localparam int SENSORS    = 14;
	localparam int GROUP_SIZE = 7;
	localparam int THR_REGS   = 8;

	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS_BTN   = 8'h08;
	localparam logic [7:0] ADDR_STATUS_GRP   = 8'h09;
	localparam logic [7:0] ADDR_GROUP_STATUS = 8'h0f;
	localparam logic [7:0] ADDR_CLOSURE_CFG  = 8'h2b;
	localparam logic [7:0] ADDR_QUEUE_CTRL   = 8'h2c;
	localparam logic [7:0] ADDR_PAT_BUTTONS  = 8'h2d;
	localparam logic [7:0] ADDR_PAT_GROUPED  = 8'h2e;
	localparam logic [7:0] ADDR_RECAL_CFG    = 8'h2f;
	localparam logic [7:0] ADDR_THR_S1       = 8'h30;
	localparam logic [7:0] ADDR_THR_GROUP    = 8'h37;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [7:0] RST_CLOSURE_CFG = 8'h00;
	localparam logic [2:0] RST_QUEUE_CTRL  = 3'h2;
	localparam logic [6:0] RST_PATTERN     = 7'h7f;
	localparam logic [7:0] RST_RECAL_CFG   = 8'h93;
	localparam logic [6:0] RST_THRESHOLD   = 7'h40;

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int CFG_ENABLE_BIT      = 7;
	localparam int CFG_EXACT_BIT       = 1;
	localparam int CFG_ALERT_BIT       = 0;
	localparam int RECAL_BUT_BCAST_BIT = 7;
	localparam int RECAL_GRP_BCAST_BIT = 6;
	localparam int RECAL_NEG_LSB       = 3;
	localparam int RECAL_TIME_LSB      = 0;
	localparam int GSTAT_CLOSURE_BIT   = 3;

	// --------------------------------------------------------------
	// Carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} lcrc_reg_req_t;

	typedef struct packed {
		logic                 valid;
		logic [SENSORS-1:0]   over;
		logic [SENSORS-1:0]   neg_delta;
	} lcrc_sample_t;

endpackage
`default_nettype wire

// [hw/lcrc_qualify.sv]
`timescale 1ns/1ns
`default_nettype none
module lcrc_qualify
	import lcrc_pkg::*;
#(
	parameter int N = SENSORS
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         sample_valid,
	input  wire logic [N-1:0] raw,
	input  wire logic [3:0]   depth,
	output logic      [N-1:0] status_q
);

	// --------------------------------------------------------------
	// Per-sensor run counters
	// --------------------------------------------------------------
	// A run counts samples that disagree with the held status, so the
	// same depth guards both the rise and the fall of each bit.
	logic [3:0] run_q [N];

	for (genvar i = 0; i < N; i++) begin : g_sens
		wire logic       differs = raw[i] != status_q[i];
		wire logic [3:0] run_inc = run_q[i] + 4'h1;
		wire logic       done    = run_inc >= depth;

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				run_q[i]    <= 4'h0;
				status_q[i] <= 1'b0;
			end else if (sample_valid) begin
				if (!differs) begin
					run_q[i] <= 4'h0;
				end else if (done) begin
					run_q[i]    <= 4'h0;
					status_q[i] <= raw[i];
				end else begin
					run_q[i] <= run_inc;
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	AST_QUAL_HOLD: assert property (@(posedge clk) disable iff (rst)
		!sample_valid |=> $stable(status_q))
		else $error("Closure status moved outside a sample");

	AST_QUAL_DEPTH1: assert property (@(posedge clk) disable iff (rst)
		(sample_valid && depth == 4'h1) |=> status_q == $past(raw))
		else $error("Depth one did not follow the raw sample");

endmodule
`default_nettype wire

// [hw/lcrc_pattern.sv]
`timescale 1ns/1ns
`default_nettype none
module lcrc_pattern
	import lcrc_pkg::*;
(
	input  wire logic [SENSORS-1:0]    status,
	input  wire logic [GROUP_SIZE-1:0] pat_btn,
	input  wire logic [GROUP_SIZE-1:0] pat_grp,
	input  wire logic                  exact,
	output logic                       hit
);

	// --------------------------------------------------------------
	// Population counts
	// --------------------------------------------------------------
	function automatic logic [2:0] pop7(input logic [6:0] v);
		logic [2:0] c;
		c = 3'h0;
		for (int k = 0; k < 7; k++) begin
			c = c + {2'h0, v[k]};
		end
		return c;
	endfunction

	wire logic [6:0] st_btn = status[6:0];
	wire logic [6:0] st_grp = status[13:7];
	wire logic [2:0] n_sb   = pop7(st_btn);
	wire logic [2:0] n_sg   = pop7(st_grp);
	wire logic [2:0] n_pb   = pop7(pat_btn);
	wire logic [2:0] n_pg   = pop7(pat_grp);
	wire logic [3:0] n_st   = {1'b0, n_sb} + {1'b0, n_sg};
	wire logic [3:0] n_pt   = {1'b0, n_pb} + {1'b0, n_pg};

	// --------------------------------------------------------------
	// Comparison
	// --------------------------------------------------------------
	wire logic exact_hit = ((st_btn & pat_btn) == pat_btn) &&
		((st_grp & pat_grp) == pat_grp);
	wire logic cnt_hit = (n_sb >= n_pb)
		|| (n_sg >= n_pg)
		|| (n_st >= n_pt);

	assign hit = exact ? exact_hit : cnt_hit;

endmodule
`default_nettype wire

// [hw/lcrc_top.sv]
// Functional notes
// - Status sets after the programmed run of samples above threshold.
// - Queue depth field of zero acts as one sample.
// - Queue works per sensor and governs both setting and clearing.
// - Patterns used only when enabled; config bit 1 picks exact or count.
// - Exact mode: every pattern bit must also be set in status.
// - Count mode: button status count at least button pattern count.
// - Count mode: grouped status count at least grouped pattern count.
// - Count mode: total counts compared; any one count condition suffices.
// - Both patterns zero disables detection and clears the event flag.
// - A detected event sets the closure flag in group status.
// - Pattern masks hold seven sensors each in bits 0-6, reset all ones.
// - Button broadcast on: sensor 1 threshold write also loads sensors 2-7.
// - Sensor 2-7 thresholds stay individually writable at all times.
// - Group broadcast on: sensor 1 write loads group threshold too.
// - Negative run of 8, 16 or 32 triggers recalibration; code 3 off.
// - Timing code picks averaged samples 16, 32, 64, else 256.
// - Timing code picks baseline update interval in polling cycles.
// - One timing setting serves every sensor alike.
// - Raw over-threshold indication feeds the queue.
// - Alert asserts for closure only when alert enable is set.
// - Detection runs only while the enable bit is set.
`timescale 1ns/1ns
`default_nettype none
module lcrc_top
	import lcrc_pkg::*;
(
	input  wire logic                              clk,
	input  wire logic                              rst,
	input  wire lcrc_reg_req_t                     reg_req,
	output logic      [7:0]                        reg_rdata,
	input  wire lcrc_sample_t                      sample,
	output logic      [SENSORS-1:0]                closure_status,
	output logic                                   closure_flag,
	output logic                                   alert,
	output logic      [THR_REGS-1:0][6:0]          thresholds,
	output logic      [8:0]                        recal_samples,
	output logic                                   baseline_update,
	output logic      [SENSORS-1:0]                recal_req
);

	// --------------------------------------------------------------
	// Decode helpers
	// --------------------------------------------------------------
	function automatic logic [8:0] samples_of(input logic [2:0] c);
		unique case (c)
			3'h0: return 9'h010;
			3'h1: return 9'h020;
			3'h2: return 9'h040;
			default: return 9'h100;
		endcase
	endfunction

	function automatic logic [12:0] interval_of(input logic [2:0] c);
		unique case (c)
			3'h0: return 13'h0010;
			3'h1: return 13'h0020;
			3'h2: return 13'h0040;
			3'h3: return 13'h0100;
			3'h4: return 13'h0400;
			3'h5: return 13'h0800;
			3'h6: return 13'h1000;
			3'h7: return 13'h1f00;
		endcase
	endfunction

	function automatic logic [5:0] neg_limit_of(input logic [1:0] c);
		unique case (c)
			2'h0: return 6'h08;
			2'h1: return 6'h10;
			2'h2: return 6'h20;
			2'h3: return 6'h00;
		endcase
	endfunction

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	logic [7:0] cfg_q;
	logic [2:0] queue_q;
	logic [6:0] pat_btn_q;
	logic [6:0] pat_grp_q;
	logic [7:0] recal_q;
	logic [6:0] thr_q [THR_REGS];

	wire logic wr = reg_req.we;
	wire logic [7:0] wa = reg_req.addr;
	wire logic [7:0] wd = reg_req.wdata;
	wire logic wr_s1 = wr && wa == ADDR_THR_S1;
	wire logic but_bcast = recal_q[RECAL_BUT_BCAST_BIT];
	wire logic grp_bcast = recal_q[RECAL_GRP_BCAST_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q     <= RST_CLOSURE_CFG;
			queue_q   <= RST_QUEUE_CTRL;
			pat_btn_q <= RST_PATTERN;
			pat_grp_q <= RST_PATTERN;
			recal_q   <= RST_RECAL_CFG;
		end else if (wr) begin
			if (wa == ADDR_CLOSURE_CFG) begin
				cfg_q <= wd;
			end
			if (wa == ADDR_QUEUE_CTRL) begin
				queue_q <= wd[2:0];
			end
			if (wa == ADDR_PAT_BUTTONS) begin
				pat_btn_q <= wd[6:0];
			end
			if (wa == ADDR_PAT_GROUPED) begin
				pat_grp_q <= wd[6:0];
			end
			if (wa == ADDR_RECAL_CFG) begin
				recal_q <= wd;
			end
		end
	end

	// --------------------------------------------------------------
	// Threshold bank
	// --------------------------------------------------------------
	// Index 0 is sensor 1, 1..6 sensors 2..7, 7 the group.
	for (genvar t = 0; t < THR_REGS; t++) begin : g_thr
		wire logic own = wr && wa == ADDR_THR_S1 + 8'(t);
		wire logic bc  = (t > 0 && t < THR_REGS - 1) ? (wr_s1 && but_bcast)
			: (t == THR_REGS - 1) ? (wr_s1 && grp_bcast) : 1'b0;
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				thr_q[t] <= RST_THRESHOLD;
			end else if (own || bc) begin
				thr_q[t] <= wd[6:0];
			end
		end
		assign thresholds[t] = thr_q[t];
	end

	// --------------------------------------------------------------
	// Qualification and pattern
	// --------------------------------------------------------------
	// Code zero widened to one; the 3-bit field tops out at seven.
	wire logic [3:0] depth = (queue_q == 3'h0) ? 4'h1
		: {1'b0, queue_q};

	lcrc_qualify #(.N(SENSORS)) u_qualify (
		.clk          (clk),
		.rst          (rst),
		.sample_valid (sample.valid),
		.raw          (sample.over),
		.depth        (depth),
		.status_q     (closure_status)
	);

	logic hit;

	lcrc_pattern u_pattern (
		.status  (closure_status),
		.pat_btn (pat_btn_q),
		.pat_grp (pat_grp_q),
		.exact   (cfg_q[CFG_EXACT_BIT]),
		.hit     (hit)
	);

	// --------------------------------------------------------------
	// Closure event flag
	// --------------------------------------------------------------
	logic eval_q;
	logic flag_q;

	wire logic masks_zero = pat_btn_q == 7'h00 && pat_grp_q == 7'h00;
	wire logic det_on = cfg_q[CFG_ENABLE_BIT] && !masks_zero;
	wire logic ev_set = eval_q && det_on && hit;
	wire logic sw_clr = wr && wa == ADDR_GROUP_STATUS && wd[GSTAT_CLOSURE_BIT];

	// Eval runs the cycle after a sample so status has settled.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eval_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			eval_q <= sample.valid;
			if (masks_zero) begin
				flag_q <= 1'b0;
			end else if (ev_set) begin
				flag_q <= 1'b1;
			end else if (sw_clr) begin
				flag_q <= 1'b0;
			end
		end
	end

	assign closure_flag = flag_q;
	assign alert = flag_q && cfg_q[CFG_ALERT_BIT];

	// --------------------------------------------------------------
	// Recalibration timing
	// --------------------------------------------------------------
	wire logic [2:0]  tcode    = recal_q[RECAL_TIME_LSB +: 3];
	wire logic [12:0] interval = interval_of(tcode);
	wire logic [5:0]  neg_lim  = neg_limit_of(recal_q[RECAL_NEG_LSB +: 2]);
	logic [12:0] poll_q;
	logic        upd_q;

	assign recal_samples = samples_of(tcode);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			poll_q <= 13'h0000;
			upd_q  <= 1'b0;
		end else begin
			upd_q <= 1'b0;
			if (sample.valid) begin
				if (poll_q + 13'h0001 >= interval) begin
					poll_q <= 13'h0000;
					upd_q  <= 1'b1;
				end else begin
					poll_q <= poll_q + 13'h0001;
				end
			end
		end
	end

	assign baseline_update = upd_q;

	// Limit of zero means the trigger is off.
	logic [5:0] neg_q [SENSORS];
	for (genvar s = 0; s < SENSORS; s++) begin : g_neg
		wire logic [5:0] nxt = neg_q[s] + 6'h01;
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				neg_q[s]     <= 6'h00;
				recal_req[s] <= 1'b0;
			end else begin
				recal_req[s] <= 1'b0;
				if (sample.valid) begin
					if (!sample.neg_delta[s] || neg_lim == 6'h00) begin
						neg_q[s] <= 6'h00;
					end else if (nxt == neg_lim) begin
						neg_q[s]     <= 6'h00;
						recal_req[s] <= 1'b1;
					end else begin
						neg_q[s] <= nxt;
					end
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Read port
	// --------------------------------------------------------------
	wire logic [2:0] thr_idx = 3'(wa - ADDR_THR_S1);
	wire logic is_thr = wa >= ADDR_THR_S1 && wa <= ADDR_THR_GROUP;
	wire logic [7:0] rd_mux =
		(wa == ADDR_STATUS_BTN)   ? {1'b0, closure_status[6:0]} :
		(wa == ADDR_STATUS_GRP)   ? {1'b0, closure_status[13:7]} :
		(wa == ADDR_GROUP_STATUS) ? 8'(flag_q) << GSTAT_CLOSURE_BIT :
		(wa == ADDR_CLOSURE_CFG)  ? cfg_q :
		(wa == ADDR_QUEUE_CTRL)   ? {5'h00, queue_q} :
		(wa == ADDR_PAT_BUTTONS)  ? {1'b0, pat_btn_q} :
		(wa == ADDR_PAT_GROUPED)  ? {1'b0, pat_grp_q} :
		(wa == ADDR_RECAL_CFG)    ? recal_q :
		is_thr                    ? {1'b0, thr_q[thr_idx]} : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.re) begin
			reg_rdata <= rd_mux;
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	AST_THR_BCAST: assert property (@(posedge clk) disable iff (rst)
		(wr_s1 && but_bcast) |=> thr_q[3] == $past(wd[6:0]))
		else $error("Button broadcast missed sensor four");

	AST_THR_INDIV: assert property (@(posedge clk) disable iff (rst)
		(wr && wa == ADDR_THR_S1 + 8'h02) |=> thr_q[2] == $past(wd[6:0]))
		else $error("Sensor three threshold not written");

	AST_GRP_HOLD: assert property (@(posedge clk) disable iff (rst)
		(wr_s1 && !grp_bcast) |=> $stable(thr_q[7]))
		else $error("Group threshold moved without broadcast");

	AST_MASK_ZERO: assert property (@(posedge clk) disable iff (rst)
		masks_zero |=> !flag_q)
		else $error("Flag set with both patterns zero");

	AST_ALERT_GATE: assert property (@(posedge clk) disable iff (rst)
		alert |-> (cfg_q[CFG_ALERT_BIT] && flag_q))
		else $error("Alert without enable");

	AST_DISABLED: assert property (@(posedge clk) disable iff (rst)
		(!cfg_q[CFG_ENABLE_BIT] && !flag_q) |=> !flag_q)
		else $error("Flag set while detection disabled");

	AST_EVENT_SET: assert property (@(posedge clk) disable iff (rst)
		(sample.valid ##1 (det_on && hit)) |=> flag_q)
		else $error("Event not flagged after sample");

	AST_RECAL_OFF: assert property (@(posedge clk) disable iff (rst)
		(recal_q[RECAL_NEG_LSB +: 2] == 2'h3) [*2] |-> recal_req == '0)
		else $error("Recalibration triggered while disabled");

	AST_BASELINE: assert property (@(posedge clk) disable iff (rst)
		baseline_update |-> $past(sample.valid))
		else $error("Baseline update without a poll");

	COV_FLAG: cover property (@(posedge clk) disable iff (rst) $rose(flag_q));
	COV_RECAL: cover property (@(posedge clk) disable iff (rst) |recal_req);
	COV_BASE: cover property (@(posedge clk) disable iff (rst) baseline_update);

endmodule
`default_nettype wire

// [verification/lcrc_host.sv]
`timescale 1ns/1ns
`default_nettype none
module lcrc_host
	import lcrc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output var  lcrc_reg_req_t req
);
	// ----------------------------------------------------------
	// Register bus requester
	// ----------------------------------------------------------
	// Extra idle cycles after the one that follows each access; raise to act as a slow host
	int gap = 0;

	initial req = '0;

	// One strobe cycle, then at least one idle edge, so the strobe
	// is never lowered and raised in the same time step
	task automatic access(input logic [7:0] a, d, input logic w,
		output logic [7:0] q);
		req = '{addr: a, wdata: d, we: w, re: !w};
		@(posedge clk);
		#1;
		q = rdata;
		req = '0;
		repeat (gap + 1) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// [verification/lcrc_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("[FAIL] %0t got %h exp %h", $time, g, e); \
	end \
end
module lcrc_tb_top;
	import lcrc_pkg::*;
	logic                     clk = 1'b0;
	logic                     rst = 1'b1;
	lcrc_reg_req_t            req;
	lcrc_sample_t             smp = '0;
	logic [7:0]               rdata, q;
	logic [SENSORS-1:0]       cst, rreq, m_st, ov;
	logic                     flag, alert, bupd, m_flag;
	logic [THR_REGS-1:0][6:0] thr, m_thr;
	logic [8:0]               rsmp;
	logic [7:0]               m_cfg, m_pb, m_pg, m_rc;
	int                       num_errors = 0;
	int                       tests_run = 0;
	int                       run[SENSORS];
	int                       depth, nvalid, n;

	lcrc_top lcrc_top_i (
		.clk             (clk),
		.rst             (rst),
		.reg_req         (req),
		.reg_rdata       (rdata),
		.sample          (smp),
		.closure_status  (cst),
		.closure_flag    (flag),
		.alert           (alert),
		.thresholds      (thr),
		.recal_samples   (rsmp),
		.baseline_update (bupd),
		.recal_req       (rreq)
	);
	lcrc_host lcrc_host_i (.clk(clk), .rdata(rdata), .req(req));

	always #4 clk = ~clk;

	// ----------------------------------------------------------
	// Reference model
	// ----------------------------------------------------------
	task automatic do_reset();
		rst = 1'b1;
		smp = '0;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		m_st = '0;
		m_flag = 1'b0;
		nvalid = 0;
		run = '{default: 0};
		m_cfg = 8'h00;
		m_pb = 8'h7f;
		m_pg = 8'h7f;
		m_rc = 8'h93;
		depth = 2;
		m_thr = {THR_REGS{7'h40}};
	endtask

	function automatic int intv(logic [2:0] c);
		int t[8] = '{16, 32, 64, 256, 1024, 2048, 4096, 7936};
		return t[c];
	endfunction

	function automatic logic ev();
		int cb, cg, pb, pg;
		cb = $countones(m_st[6:0]);
		cg = $countones(m_st[13:7]);
		pb = $countones(m_pb);
		pg = $countones(m_pg);
		if (!m_cfg[7] || pb + pg == 0)
			return 1'b0;
		if (m_cfg[1])
			return ((m_st[6:0] & m_pb[6:0]) == m_pb[6:0]) &&
				((m_st[13:7] & m_pg[6:0]) == m_pg[6:0]);
		return cb >= pb || cg >= pg || cb + cg >= pb + pg;
	endfunction

	task automatic wr(input logic [7:0] a, d);
		lcrc_host_i.access(a, d, 1'b1, q);
		if (a == ADDR_CLOSURE_CFG) m_cfg = d;
		if (a == ADDR_QUEUE_CTRL) depth = (d[2:0] == 0) ? 1 : d[2:0];
		if (a == ADDR_PAT_BUTTONS) m_pb = d & 8'h7f;
		if (a == ADDR_PAT_GROUPED) m_pg = d & 8'h7f;
		if (a == ADDR_RECAL_CFG) m_rc = d;
		if (a == ADDR_GROUP_STATUS && d[3]) m_flag = 1'b0;
		if (a > ADDR_THR_S1 && a <= ADDR_THR_GROUP) m_thr[a[2:0]] = d[6:0];
		if (a == ADDR_THR_S1) begin
			for (int i = 0; i < 7; i++)
				if (i == 0 || m_rc[7]) m_thr[i] = d[6:0];
			if (m_rc[6]) m_thr[7] = d[6:0];
		end
		if (m_pb == 0 && m_pg == 0) m_flag = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, e);
		lcrc_host_i.access(a, 8'h00, 1'b0, q);
		`CHK(q, e)
	endtask

	// Status checked one cycle after valid, flag one cycle later
	task automatic sample(input logic [SENSORS-1:0] o, nd, rq);
		smp = '{valid: 1'b1, over: o, neg_delta: nd};
		@(posedge clk);
		#1;
		smp.valid = 1'b0;
		nvalid++;
		for (int i = 0; i < SENSORS; i++) begin
			run[i] = (o[i] != m_st[i]) ? run[i] + 1 : 0;
			if (run[i] >= depth) begin
				m_st[i] = o[i];
				run[i] = 0;
			end
		end
		`CHK(cst, m_st)
		`CHK(rreq, rq)
		`CHK(bupd, nvalid % intv(m_rc[2:0]) == 0)
		@(posedge clk);
		#1;
		if (ev()) m_flag = 1'b1;
		`CHK(flag, m_flag)
		`CHK(alert, m_flag & m_cfg[0])
	endtask

	task automatic summarize();
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------
	// Tests
	// ----------------------------------------------------------
	initial begin
		void'($urandom(87));
		do_reset();
		rd(ADDR_CLOSURE_CFG, 8'h00);
		rd(ADDR_QUEUE_CTRL, 8'h02);
		rd(ADDR_PAT_BUTTONS, 8'h7f);
		rd(ADDR_PAT_GROUPED, 8'h7f);
		rd(ADDR_RECAL_CFG, 8'h93);
		rd(8'h50, 8'h00);
		wr(ADDR_QUEUE_CTRL, 8'hff);
		rd(ADDR_QUEUE_CTRL, 8'h07);
		wr(ADDR_PAT_BUTTONS, 8'hff);
		rd(ADDR_PAT_BUTTONS, 8'h7f);
		`CHK(rsmp, 9'd256)
		for (int t = 0; t < 8; t++) begin
			wr(ADDR_RECAL_CFG, {t[1:0], 3'b010, t[2:0]});
			rd(ADDR_RECAL_CFG, {t[1:0], 3'b010, t[2:0]});
			`CHK(rsmp, 9'((t < 3) ? 16 << t : 256))
			wr(ADDR_THR_GROUP, 8'($urandom));
			wr(ADDR_THR_S1, 8'($urandom));
			wr(ADDR_THR_S1 + 8'(1 + t % 6), 8'($urandom));
			`CHK(thr, m_thr)
		end
		// Every depth code, both compare modes, disabled and empty masks
		for (int r = 0; r < 16; r++) begin
			do_reset();
			lcrc_host_i.gap = $urandom % 3;
			wr(ADDR_QUEUE_CTRL, 8'(r % 8));
			wr(ADDR_CLOSURE_CFG, {r != 2, 5'h00, 2'($urandom)});
			wr(ADDR_PAT_BUTTONS,
				(r == 1 || $urandom % 4 == 0) ? 8'h00 : 8'($urandom));
			wr(ADDR_PAT_GROUPED,
				(r == 1 || $urandom % 4 == 0) ? 8'h00 : 8'($urandom));
			ov = '0;
			for (int k = 0; k < 30; k++) begin
				ov = ov ^ (SENSORS'($urandom) & SENSORS'($urandom));
				sample(ov, '0, '0);
			end
			rd(ADDR_STATUS_BTN, {1'b0, m_st[6:0]});
			rd(ADDR_STATUS_GRP, {1'b0, m_st[13:7]});
			rd(ADDR_GROUP_STATUS, {4'h0, m_flag, 3'h0});
			if (r % 2) begin
				wr(ADDR_GROUP_STATUS, 8'h08);
			end else begin
				wr(ADDR_PAT_BUTTONS, 8'h00);
				wr(ADDR_PAT_GROUPED, 8'h00);
			end
			`CHK(flag, m_flag)
		end
		// Negative run broken once, then a full run; code 3 never fires
		for (int c = 0; c < 4; c++) begin
			do_reset();
			wr(ADDR_RECAL_CFG, 8'(c << 3 | c % 2));
			n = (c == 3) ? 40 : 8 << c;
			for (int k = 1; k <= 2 * n; k++)
				sample(SENSORS'($urandom), {SENSORS{k != n}},
					{SENSORS{c < 3 && k == 2 * n}});
		end
		summarize();
	end

	// Tests take about 2000 cycles; cut off at 12500
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
